/* File: rtl/safe_cfg_reg.sv */
// Purpose: One masked 8-bit configuration register
// Assumes: Write strobe and default command are synchronous to mclk_i
// Notes: Masked bits hold zero forever
`timescale 1ns/1ns
module safe_cfg_reg #(
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // Control
  input wire logic defaults_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // Value
  output logic [7:0] value_o
);
  import safe_pkg::*;

  logic [7:0] value_d;

  // Default command outranks a write in the same cycle
  assign value_d = defaults_i ? SAFE_RST_VAL :
                   wr_i ? (wdata_i & WR_MASK) : value_o;

  // Storage
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value_o <= SAFE_RST_VAL;
    end else if (clk_en_i) begin
      value_o <= value_d;
    end
  end
endmodule

/* File: rtl/safe_pkg.sv */
// Purpose: Shared constants for the analog configuration register bank
// Assumes: 8-bit registers behind a byte-wide register port
// Notes: All reset values are zero
package safe_pkg;
  localparam int unsigned SAFE_AW = 8;
  localparam int unsigned SAFE_DW = 8;
  // Register offsets
  localparam logic [7:0] SAFE_OFS_GAS = 8'h0D;
  localparam logic [7:0] SAFE_OFS_LEDSUP = 8'h0F;
  localparam logic [7:0] SAFE_OFS_PHOTO = 8'h10;
  localparam logic [7:0] SAFE_OFS_LEDA = 8'h11;
  localparam logic [7:0] SAFE_OFS_LEDB = 8'h12;
  // Reset values
  localparam logic [7:0] SAFE_RST_VAL = 8'h00;
  // Writable bit masks; cleared bits are reserved and read zero
  localparam logic [7:0] SAFE_MSK_GAS = 8'hFF;
  localparam logic [7:0] SAFE_MSK_LEDSUP = 8'h0E;
  localparam logic [7:0] SAFE_MSK_PHOTO = 8'h7F;
  localparam logic [7:0] SAFE_MSK_DAC = 8'hFF;
  // Field positions, gas amplifier register
  localparam int unsigned SAFE_GAS_REFBUF = 7;
  localparam int unsigned SAFE_GAS_REF_HI = 6;
  localparam int unsigned SAFE_GAS_REF_LO = 5;
  localparam int unsigned SAFE_GAS_FB_HI = 4;
  localparam int unsigned SAFE_GAS_FB_LO = 3;
  localparam int unsigned SAFE_GAS_DIR = 2;
  localparam int unsigned SAFE_GAS_TEST = 1;
  localparam int unsigned SAFE_GAS_AMP = 0;
  // Field positions, LED supply register
  localparam int unsigned SAFE_SUP_HI = 3;
  localparam int unsigned SAFE_SUP_LO = 1;
  // Field positions, photo chain register
  localparam int unsigned SAFE_PH_B_HI = 6;
  localparam int unsigned SAFE_PH_B_LO = 5;
  localparam int unsigned SAFE_PH_A_HI = 4;
  localparam int unsigned SAFE_PH_A_LO = 3;
  localparam int unsigned SAFE_PH_REF = 2;
  localparam int unsigned SAFE_PH_G_HI = 1;
  localparam int unsigned SAFE_PH_G_LO = 0;
  // Highest legal supply code
  localparam logic [2:0] SAFE_SUP_MAX = 3'h5;
endpackage

/* File: rtl/safe_regs.sv */
// Purpose: Analog front end configuration bank for gas and photo chains
// Assumes: Serial host port already decoded into byte read and write strobes
// Notes: Read data registered one cycle after the read strobe
//
// How it works
// - Gas reference select in bits 6-5, codes pick 1.25 to 5 mV.
// - Gas feedback resistance select in bits 4-3, four resistor values.
// - Bit 7 turns the 300 mV reference buffer on.
// - Bit 2 picks test output pull direction, one means pull-up.
// - Bit 1 routes the gas test output onto the photo reference pin.
// - Bit 0 switches the gas amplifier on.
// - LED supply code in bits 3-1; other bits reserved, read zero.
// - LED B drift code in photo register bits 6-5.
// - LED A drift code in photo register bits 4-3.
// - Bit 2 references photo gain to 50 mV internal reference.
// - Bits 1-0 select photo gain of 5, 11, 20 or 35.
// - Each LED level register holds a full 8-bit DAC code.
// - Five registers at 0Dh, 0Fh, 10h, 11h, 12h reset to zero.
// - Default command returns all five registers to zero on each enabled edge while it is held high.
`timescale 1ns/1ns
module safe_regs (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // Register port from the serial host interface
  input wire logic [safe_pkg::SAFE_AW-1:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [safe_pkg::SAFE_DW-1:0] wdata_i,
  input wire logic register_default_cmd_i,
  output logic [safe_pkg::SAFE_DW-1:0] rdata_o,
  output logic rvalid_o,
  output logic hit_o,
  // Gas amplifier controls
  output logic ref_buffer_on_o,
  output logic [1:0] gas_ref_level_o,
  output logic [1:0] gas_feedback_sel_o,
  output logic gas_test_pull_dir_o,
  output logic gas_test_out_on_o,
  output logic gas_amp_on_o,
  // LED supply
  output logic [2:0] led_supply_code_o,
  output logic led_supply_code_bad_o,
  // Photo chain controls
  output logic [1:0] led_b_drift_code_o,
  output logic [1:0] led_a_drift_code_o,
  output logic photo_ref_select_o,
  output logic [1:0] photo_gain_code_o,
  // LED current DAC codes
  output logic [7:0] led_a_level_code_o,
  output logic [7:0] led_b_level_code_o
);
  import safe_pkg::*;

  logic [7:0] co_amp_config;
  logic [7:0] led_supply_voltage;
  logic [7:0] photo_chain_config;
  logic [7:0] led_a_current_code;
  logic [7:0] led_b_current_code;
  logic [7:0] rdata_d;
  logic hit_d;
  logic sel_gas;
  logic sel_sup;
  logic sel_ph;
  logic sel_la;
  logic sel_lb;
  logic ref_buffer_on_d;
  logic [1:0] gas_ref_level_d;
  logic [1:0] gas_feedback_sel_d;
  logic gas_test_pull_dir_d;
  logic gas_test_out_on_d;
  logic gas_amp_on_d;
  logic [2:0] led_supply_code_d;
  logic led_supply_code_bad_d;
  logic [1:0] led_b_drift_code_d;
  logic [1:0] led_a_drift_code_d;
  logic photo_ref_select_d;
  logic [1:0] photo_gain_code_d;
  logic [7:0] led_a_level_code_d;
  logic [7:0] led_b_level_code_d;

  // Address decode
  assign sel_gas = (addr_i == SAFE_OFS_GAS);
  assign sel_sup = (addr_i == SAFE_OFS_LEDSUP);
  assign sel_ph = (addr_i == SAFE_OFS_PHOTO);
  assign sel_la = (addr_i == SAFE_OFS_LEDA);
  assign sel_lb = (addr_i == SAFE_OFS_LEDB);

  // Gas amplifier register, all bits writable
  safe_cfg_reg #(.WR_MASK(SAFE_MSK_GAS)) u_gas (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clk_en_i(clk_en_i),
    .defaults_i(register_default_cmd_i),
    .wr_i(wr_en_i && sel_gas),
    .wdata_i(wdata_i),
    .value_o(co_amp_config)
  );

  // Supply register keeps only bits 3-1; the mask protects reserved bits
  safe_cfg_reg #(.WR_MASK(SAFE_MSK_LEDSUP)) u_sup (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clk_en_i(clk_en_i),
    .defaults_i(register_default_cmd_i),
    .wr_i(wr_en_i && sel_sup),
    .wdata_i(wdata_i),
    .value_o(led_supply_voltage)
  );

  // Photo chain register, bit 7 reserved
  safe_cfg_reg #(.WR_MASK(SAFE_MSK_PHOTO)) u_ph (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clk_en_i(clk_en_i),
    .defaults_i(register_default_cmd_i),
    .wr_i(wr_en_i && sel_ph),
    .wdata_i(wdata_i),
    .value_o(photo_chain_config)
  );

  // LED A DAC code, full byte
  safe_cfg_reg #(.WR_MASK(SAFE_MSK_DAC)) u_la (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clk_en_i(clk_en_i),
    .defaults_i(register_default_cmd_i),
    .wr_i(wr_en_i && sel_la),
    .wdata_i(wdata_i),
    .value_o(led_a_current_code)
  );

  // LED B DAC code, full byte
  safe_cfg_reg #(.WR_MASK(SAFE_MSK_DAC)) u_lb (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clk_en_i(clk_en_i),
    .defaults_i(register_default_cmd_i),
    .wr_i(wr_en_i && sel_lb),
    .wdata_i(wdata_i),
    .value_o(led_b_current_code)
  );

  // Read mux; unmapped offsets read zero and drop the hit flag
  assign rdata_d = sel_gas ? co_amp_config :
                   sel_sup ? led_supply_voltage :
                   sel_ph ? photo_chain_config :
                   sel_la ? led_a_current_code :
                   sel_lb ? led_b_current_code : SAFE_RST_VAL;
  assign hit_d = sel_gas | sel_sup | sel_ph | sel_la | sel_lb;

  // Read answer, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= SAFE_RST_VAL;
      rvalid_o <= 1'b0;
      hit_o <= 1'b0;
    end else if (clk_en_i) begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= rdata_d;
        hit_o <= hit_d;
      end
    end
  end

  // Field slices of the gas amplifier register
  assign ref_buffer_on_d = co_amp_config[SAFE_GAS_REFBUF];
  assign gas_ref_level_d = co_amp_config[SAFE_GAS_REF_HI:SAFE_GAS_REF_LO];
  assign gas_feedback_sel_d = co_amp_config[SAFE_GAS_FB_HI:SAFE_GAS_FB_LO];
  assign gas_test_pull_dir_d = co_amp_config[SAFE_GAS_DIR];
  assign gas_test_out_on_d = co_amp_config[SAFE_GAS_TEST];
  assign gas_amp_on_d = co_amp_config[SAFE_GAS_AMP];

  // Supply field; codes 6 and 7 are kept as written and only flagged
  assign led_supply_code_d = led_supply_voltage[SAFE_SUP_HI:SAFE_SUP_LO];
  assign led_supply_code_bad_d = (led_supply_code_d > SAFE_SUP_MAX);

  // Field slices of the photo chain register
  assign led_b_drift_code_d = photo_chain_config[SAFE_PH_B_HI:SAFE_PH_B_LO];
  assign led_a_drift_code_d = photo_chain_config[SAFE_PH_A_HI:SAFE_PH_A_LO];
  assign photo_ref_select_d = photo_chain_config[SAFE_PH_REF];
  assign photo_gain_code_d = photo_chain_config[SAFE_PH_G_HI:SAFE_PH_G_LO];

  // Level codes pass through whole
  assign led_a_level_code_d = led_a_current_code;
  assign led_b_level_code_d = led_b_current_code;

  // Every field output is registered again so analog controls see clean
  // levels; costs one cycle of latency after a write
  // Reference buffer enable
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_buffer_on_o <= 1'b0;
    end else if (clk_en_i) begin
      ref_buffer_on_o <= ref_buffer_on_d;
    end
  end

  // Gas reference level
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gas_ref_level_o <= 2'h0;
    end else if (clk_en_i) begin
      gas_ref_level_o <= gas_ref_level_d;
    end
  end

  // Gas feedback resistor select
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gas_feedback_sel_o <= 2'h0;
    end else if (clk_en_i) begin
      gas_feedback_sel_o <= gas_feedback_sel_d;
    end
  end

  // Test output pull direction
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gas_test_pull_dir_o <= 1'b0;
    end else if (clk_en_i) begin
      gas_test_pull_dir_o <= gas_test_pull_dir_d;
    end
  end

  // Test output routing onto the photo reference pin
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gas_test_out_on_o <= 1'b0;
    end else if (clk_en_i) begin
      gas_test_out_on_o <= gas_test_out_on_d;
    end
  end

  // Gas amplifier power
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gas_amp_on_o <= 1'b0;
    end else if (clk_en_i) begin
      gas_amp_on_o <= gas_amp_on_d;
    end
  end

  // LED supply voltage code
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_supply_code_o <= 3'h0;
    end else if (clk_en_i) begin
      led_supply_code_o <= led_supply_code_d;
    end
  end

  // Flags a host that broke the supply code limit
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_supply_code_bad_o <= 1'b0;
    end else if (clk_en_i) begin
      led_supply_code_bad_o <= led_supply_code_bad_d;
    end
  end

  // LED B drift code
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_b_drift_code_o <= 2'h0;
    end else if (clk_en_i) begin
      led_b_drift_code_o <= led_b_drift_code_d;
    end
  end

  // LED A drift code
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_a_drift_code_o <= 2'h0;
    end else if (clk_en_i) begin
      led_a_drift_code_o <= led_a_drift_code_d;
    end
  end

  // Photo reference select
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      photo_ref_select_o <= 1'b0;
    end else if (clk_en_i) begin
      photo_ref_select_o <= photo_ref_select_d;
    end
  end

  // Photo gain code
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      photo_gain_code_o <= 2'h0;
    end else if (clk_en_i) begin
      photo_gain_code_o <= photo_gain_code_d;
    end
  end

  // LED A level code
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_a_level_code_o <= SAFE_RST_VAL;
    end else if (clk_en_i) begin
      led_a_level_code_o <= led_a_level_code_d;
    end
  end

  // LED B level code
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_b_level_code_o <= SAFE_RST_VAL;
    end else if (clk_en_i) begin
      led_b_level_code_o <= led_b_level_code_d;
    end
  end
endmodule

/* File: sim/safe_host_mdl.sv */
// Purpose: Host model for the register port
// Assumes: Tasks are entered just after a rising edge
// Notes: Answer taken mid-cycle, clear of the edge
`timescale 1ns/1ns
module safe_host_mdl (
  // Clock
  input wire logic mclk_i,
  // Register port
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i
);
  // Write; strobe stays up so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h0F && d[3:1] > 3'h5)
      d[3:1] = 3'h5;
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
  endtask
  // Read; bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    addr_o <= a;
    wr_o <= 1'b0;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    repeat (3) begin
      @(negedge mclk_i);
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end
    end
    @(posedge mclk_i);
  endtask
endmodule

/* File: sim/safe_regs_chk.sv */
// Purpose: Port checker for the configuration bank
// Assumes: One clock domain, async active-low reset
// Notes: Fields lag an accepted write by two edges
`timescale 1ns/1ns
module safe_regs_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic register_default_cmd_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic hit_o,
  // Fields
  input wire logic gas_amp_on_o,
  input wire logic [2:0] led_supply_code_o,
  input wire logic [7:0] led_a_level_code_o,
  input wire logic [7:0] led_b_level_code_o
);
  import safe_pkg::*;
  // Slices named so that the past value is of a plain signal
  wire logic w_amp = wdata_i[0];
  wire logic [2:0] w_sup = wdata_i[3:1];
  wire logic rd_w = clk_en_i && rd_en_i;
  wire logic map_w = addr_i == SAFE_OFS_GAS ||
    (addr_i >= SAFE_OFS_LEDSUP && addr_i <= SAFE_OFS_LEDB);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Command taken, then one more enabled edge for the field update
  sequence s_wr(logic [7:0] a);
    clk_en_i && wr_en_i && !register_default_cmd_i && addr_i == a ##1 clk_en_i;
  endsequence
  sequence s_dflt;
    clk_en_i && register_default_cmd_i ##1 clk_en_i;
  endsequence
  AST_RV: assert property (rd_w |=> rvalid_o) else $error("read not answered");
  // A frozen enable holds the answer, so only enabled edges are judged
  AST_RV_SRC: assert property ($past(clk_en_i) && rvalid_o |-> $past(rd_en_i))
    else $error("stray answer");
  AST_AMP: assert property (s_wr(SAFE_OFS_GAS) |=> gas_amp_on_o == $past(w_amp, 2))
    else $error("amp field wrong");
  AST_SUP: assert property (s_wr(SAFE_OFS_LEDSUP) |=>
    led_supply_code_o == $past(w_sup, 2)) else $error("supply field wrong");
  AST_DACA: assert property (s_wr(SAFE_OFS_LEDA) |=>
    led_a_level_code_o == $past(wdata_i, 2)) else $error("level a wrong");
  AST_DACB: assert property (s_wr(SAFE_OFS_LEDB) |=>
    led_b_level_code_o == $past(wdata_i, 2)) else $error("level b wrong");
  AST_UNMAP: assert property (rd_w && !map_w |=> !hit_o && rdata_o == 8'h00)
    else $error("unmapped read wrong");
  AST_RSV: assert property (rd_w && addr_i == SAFE_OFS_LEDSUP |=>
    (rdata_o & 8'hF1) == 8'h00) else $error("reserved bits set");
  AST_DFLT: assert property (s_dflt |=> !gas_amp_on_o && led_a_level_code_o == 8'h00)
    else $error("default not applied");
endmodule
bind safe_regs safe_regs_chk u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
  .register_default_cmd_i(register_default_cmd_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .hit_o(hit_o), .gas_amp_on_o(gas_amp_on_o),
  .led_supply_code_o(led_supply_code_o), .led_a_level_code_o(led_a_level_code_o),
  .led_b_level_code_o(led_b_level_code_o)
);

/* File: sim/tb_smoke_afe_analog_config_regs.sv */
// Purpose: Self-checking bench for the configuration bank
// Assumes: Host model issues all reads and writes; the bench drives the default command
// Notes: Fields are looked at well after their write
`timescale 1ns/1ns
module tb_smoke_afe_analog_config_regs;
  import safe_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic register_default_cmd_i = 1'b0;
  logic wr_en_i, rd_en_i, rvalid_o, hit_o, ref_buffer_on_o, gas_test_pull_dir_o;
  logic gas_test_out_on_o, gas_amp_on_o, led_supply_code_bad_o, photo_ref_select_o;
  logic [1:0] gas_ref_level_o, gas_feedback_sel_o, led_b_drift_code_o, led_a_drift_code_o;
  logic [1:0] photo_gain_code_o;
  logic [2:0] led_supply_code_o;
  logic [7:0] addr_i, wdata_i, rdata_o, led_a_level_code_o, led_b_level_code_o;
  logic [7:0] ofs [5] = '{SAFE_OFS_GAS, SAFE_OFS_LEDSUP, SAFE_OFS_PHOTO, SAFE_OFS_LEDA, 8'h12};
  int fails = 0;
  int cmp_count = 0;
  // Fields packed in register order
  wire logic [7:0] gas_w = {ref_buffer_on_o, gas_ref_level_o, gas_feedback_sel_o,
    gas_test_pull_dir_o, gas_test_out_on_o, gas_amp_on_o};
  wire logic [7:0] ph_w = {1'b0, led_b_drift_code_o, led_a_drift_code_o, photo_ref_select_o,
    photo_gain_code_o};
  safe_regs uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
    .register_default_cmd_i(register_default_cmd_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .hit_o(hit_o), .ref_buffer_on_o(ref_buffer_on_o), .gas_ref_level_o(gas_ref_level_o),
    .gas_feedback_sel_o(gas_feedback_sel_o), .gas_test_pull_dir_o(gas_test_pull_dir_o),
    .gas_test_out_on_o(gas_test_out_on_o), .gas_amp_on_o(gas_amp_on_o),
    .led_supply_code_o(led_supply_code_o), .led_supply_code_bad_o(led_supply_code_bad_o),
    .led_b_drift_code_o(led_b_drift_code_o), .led_a_drift_code_o(led_a_drift_code_o),
    .photo_ref_select_o(photo_ref_select_o), .photo_gain_code_o(photo_gain_code_o),
    .led_a_level_code_o(led_a_level_code_o), .led_b_level_code_o(led_b_level_code_o));
  safe_host_mdl h (.mclk_i(mclk_i), .addr_o(addr_i), .wr_o(wr_en_i), .rd_o(rd_en_i),
    .wdata_o(wdata_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o));
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read and compare; a lost answer ends the run
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    h.rd(a, d, ok);
    if (!ok) begin
      fails++;
      finish_test();
    end else begin
      chk(d, e);
    end
  endtask
  // Patterns hit codes 1 to 3 of the two-bit fields in bits 6-3, but only codes 0 and 3 of photo gain
  task automatic t_fields();
    logic [7:0] v [3] = '{8'h2B, 8'hD4, 8'hFF};
    foreach (ofs[i]) rdc(ofs[i], 8'h00);
    foreach (v[i]) begin
      h.wr(SAFE_OFS_GAS, v[i]);
      h.wr(SAFE_OFS_PHOTO, v[i]);
      rdc(SAFE_OFS_PHOTO, v[i] & 8'h7F);
      chk(gas_w, v[i]);
      chk(ph_w, v[i] & 8'h7F);
    end
    $display("fields done");
  endtask
  // Unmapped offset, frozen enable, reserved supply bits
  task automatic t_misc();
    h.wr(8'h0E, 8'hFF);
    rdc(8'h0E, 8'h00);
    chk({7'h0, hit_o}, 8'h00);
    clk_en_i <= 1'b0;
    h.wr(SAFE_OFS_GAS, 8'h00);
    clk_en_i <= 1'b1;
    h.wr(SAFE_OFS_LEDSUP, 8'hFB);
    rdc(SAFE_OFS_GAS, 8'hFF);
    rdc(SAFE_OFS_LEDSUP, 8'h0A);
    chk({7'h0, hit_o}, 8'h01);
    chk({5'h0, led_supply_code_o}, 8'h05);
    chk({7'h0, led_supply_code_bad_o}, 8'h00);
    $display("misc done");
  endtask
  // Back-to-back level writes, then default beating a write
  task automatic t_dac_dflt();
    h.wr(SAFE_OFS_LEDA, 8'hFF);
    h.wr(SAFE_OFS_LEDB, 8'h5A);
    rdc(SAFE_OFS_LEDB, 8'h5A);
    chk(led_a_level_code_o, 8'hFF);
    chk(led_b_level_code_o, 8'h5A);
    register_default_cmd_i <= 1'b1;
    h.wr(SAFE_OFS_GAS, 8'h81);
    register_default_cmd_i <= 1'b0;
    foreach (ofs[i]) rdc(ofs[i], 8'h00);
    chk(gas_w | ph_w | led_a_level_code_o, 8'h00);
    chk(led_b_level_code_o | {5'h0, led_supply_code_o}, 8'h00);
    $display("dac and default done");
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_fields();
    t_misc();
    t_dac_dflt();
    finish_test();
  end
endmodule
